// ===== core/fpec_top.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "fpec_consts.svh"

module fpec_top
(
   input wire logic CLOCK_I, // system clock, 10 MHz
   input wire logic RST_B_I, // synchronous reset, active low
   input wire logic POWER_ON_I, // high with reset when it is a power-on reset
   input fpec_pkg::fpec_ahb_in_type AHB_I, // ahb-lite slave inputs
   output fpec_pkg::fpec_ahb_out_type AHB_O, // ahb-lite slave outputs
   output fpec_pkg::fpec_flash_req_type FLASH_REQ_O, // request to flash array
   input fpec_pkg::fpec_flash_rsp_type FLASH_RSP_I, // flash array answer
   input wire logic LOW_SUPPLY_I, // raw low-supply detector level
   output logic LVD_EN_O, // low-supply detector power
   output logic IRQ_O // level interrupt
);
   import fpec_pkg::*;

   fpec_state_type st;
   fpec_state_type next_st;
   fpec_lvd_state_type lvd;

   logic addr_phase;
   logic wr_ctrl;
   logic wr_key;
   logic wr_addr;
   logic wr_stat;
   logic wr_mask;
   logic [2:0] events;
   logic start_ok;
   logic [31:0] rd_value;

   ////////////////////////////////////////////////////////////////////////////
   // low-supply qualifier
   fpec_lvd u_lvd
   (
      .clock_i(CLOCK_I),
      .rst_b_i(RST_B_I),
      .enable_i(st.lvd_en),
      .low_supply_i(LOW_SUPPLY_I),
      .lvd_o(lvd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // write decode for the data phase
   always_comb
   begin
      wr_ctrl = 1'b0;
      wr_key = 1'b0;
      wr_addr = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (st.dp_write && st.dp_addr == `FPEC_OFF_CTRL)
      begin
         wr_ctrl = 1'b1;
      end
      else if (st.dp_write && st.dp_addr == `FPEC_OFF_KEY)
      begin
         wr_key = 1'b1;
      end
      else if (st.dp_write && st.dp_addr == `FPEC_OFF_ADDR)
      begin
         wr_addr = 1'b1;
      end
      else if (st.dp_write && st.dp_addr == `FPEC_OFF_STAT)
      begin
         wr_stat = 1'b1;
      end
      else if (st.dp_write && st.dp_addr == `FPEC_OFF_MASK)
      begin
         wr_mask = 1'b1;
      end
   end

   // valid address phase on the bus
   assign addr_phase = AHB_I.hsel & AHB_I.htrans[1] & AHB_I.hready;

   // a start needs arm, fresh keys and an idle sequencer
   assign start_ok = wr_ctrl & AHB_I.hwdata[`FPEC_BIT_START] & st.arm & st.unlocked
      & (st.fsm == FPEC_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      next_st = st;
      events = `FPEC_ZERO_IRQ;

      // arm bit follows every control write
      if (wr_ctrl)
      begin
         next_st.arm = AHB_I.hwdata[`FPEC_BIT_ARM];
      end

      // operation code only while disarmed and idle
      if (wr_ctrl && !st.arm && st.fsm == FPEC_IDLE)
      begin
         next_st.op = AHB_I.hwdata[`FPEC_OP_HI:`FPEC_OP_LO];
      end

      // target address frozen while busy
      if (wr_addr && st.fsm == FPEC_IDLE)
      begin
         next_st.addr = AHB_I.hwdata;
      end

      // key sequence: first key then second, no other write in between
      if (wr_key)
      begin
         next_st.key_seen = (AHB_I.hwdata == `FPEC_KEY_FIRST);
         next_st.unlocked = st.key_seen && (AHB_I.hwdata == `FPEC_KEY_SECOND);
      end
      else if (st.dp_write)
      begin
         next_st.key_seen = 1'b0;
         next_st.unlocked = 1'b0;
      end

      // launch
      if (start_ok)
      begin
         next_st.start = 1'b1;
         next_st.fsm = FPEC_CHECK;
      end

      // sequencer
      case (st.fsm)
         FPEC_IDLE:
         begin
            next_st.req.valid = 1'b0;
         end
         FPEC_CHECK:
         begin
            case (st.op)
               `FPEC_OP_CLEAR:
               begin
                  next_st.fail = 1'b0;
                  next_st.fault = 1'b0;
                  next_st.fsm = FPEC_FINISH;
               end
               `FPEC_OP_CHIP:
               begin
                  if (FLASH_RSP_I.any_prot)
                  begin
                     next_st.fail = 1'b1;
                     events[`FPEC_IRQ_FAIL] = 1'b1;
                     next_st.fsm = FPEC_FINISH;
                  end
                  else
                  begin
                     next_st.req.valid = 1'b1;
                     next_st.fsm = FPEC_BUSY;
                  end
               end
               `FPEC_OP_PAGE, `FPEC_OP_ROW, `FPEC_OP_WORD:
               begin
                  if (FLASH_RSP_I.target_prot)
                  begin
                     next_st.fail = 1'b1;
                     events[`FPEC_IRQ_FAIL] = 1'b1;
                     next_st.fsm = FPEC_FINISH;
                  end
                  else
                  begin
                     next_st.req.valid = 1'b1;
                     next_st.fsm = FPEC_BUSY;
                  end
               end
               default:
               begin
                  next_st.fsm = FPEC_FINISH;
               end
            endcase
         end
         FPEC_BUSY:
         begin
            if (FLASH_RSP_I.done)
            begin
               next_st.req.valid = 1'b0;
               next_st.fsm = FPEC_FINISH;
               if (FLASH_RSP_I.err)
               begin
                  next_st.fail = 1'b1;
                  events[`FPEC_IRQ_FAIL] = 1'b1;
               end
            end
         end
         FPEC_FINISH:
         begin
            next_st.start = 1'b0;
            events[`FPEC_IRQ_DONE] = 1'b1;
            next_st.fsm = FPEC_IDLE;
         end
         default:
         begin
            next_st.fsm = FPEC_IDLE;
         end
      endcase

      // request carries the frozen code and address
      next_st.req.op = next_st.op;
      next_st.req.addr = next_st.addr;

      // low supply while the detector is on
      if (lvd.live)
      begin
         next_st.fault = 1'b1;
      end
      events[`FPEC_IRQ_FAULT] = lvd.rise;

      // detector power follows arm
      next_st.lvd_en = next_st.arm;

      // sticky status: a set wins over a write-one clear
      if (wr_stat)
      begin
         next_st.irq_stat = st.irq_stat & ~AHB_I.hwdata[`FPEC_IRQ_W-1:0];
      end
      next_st.irq_stat = next_st.irq_stat | events;
      if (wr_mask)
      begin
         next_st.irq_mask = AHB_I.hwdata[`FPEC_IRQ_W-1:0];
      end
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

      // bus address phase capture
      next_st.dp_write = addr_phase & AHB_I.hwrite;
      next_st.dp_addr = AHB_I.haddr[7:0];
      next_st.ahb.hreadyout = 1'b1;
      next_st.ahb.hresp = 1'b0;
      next_st.ahb.hrdata = `FPEC_ZERO32;
      if (addr_phase && !AHB_I.hwrite)
      begin
         next_st.ahb.hrdata = rd_value;
      end

      // resets: power-on clears all, others keep fail, fault, code and address
      if (!RST_B_I)
      begin
         next_st.arm = 1'b0;
         next_st.lvd_en = 1'b0;
         next_st.start = 1'b0;
         next_st.fsm = FPEC_IDLE;
         next_st.key_seen = 1'b0;
         next_st.unlocked = 1'b0;
         next_st.dp_write = 1'b0;
         next_st.dp_addr = `FPEC_ZERO8;
         next_st.irq_stat = `FPEC_ZERO_IRQ;
         next_st.irq_mask = `FPEC_ZERO_IRQ;
         next_st.irq = 1'b0;
         next_st.ahb.hreadyout = 1'b1;
         next_st.ahb.hresp = 1'b0;
         next_st.ahb.hrdata = `FPEC_ZERO32;
         next_st.req.valid = 1'b0;
         if (POWER_ON_I)
         begin
            next_st.fail = 1'b0;
            next_st.fault = 1'b0;
            next_st.op = `FPEC_ZERO4;
            next_st.addr = `FPEC_ZERO32;
         end
         next_st.req.op = next_st.op;
         next_st.req.addr = next_st.addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux over the freshest values, so a write just ahead is seen
   always_comb
   begin
      rd_value = `FPEC_ZERO32;
      if (AHB_I.haddr[7:0] == `FPEC_OFF_CTRL)
      begin
         rd_value[`FPEC_BIT_START] = next_st.start;
         rd_value[`FPEC_BIT_ARM] = next_st.arm;
         rd_value[`FPEC_BIT_FAIL] = next_st.fail;
         rd_value[`FPEC_BIT_FAULT] = next_st.fault;
         rd_value[`FPEC_BIT_LIVE] = lvd.live;
         rd_value[`FPEC_OP_HI:`FPEC_OP_LO] = next_st.op;
      end
      else if (AHB_I.haddr[7:0] == `FPEC_OFF_ADDR)
      begin
         rd_value = next_st.addr;
      end
      else if (AHB_I.haddr[7:0] == `FPEC_OFF_STAT)
      begin
         rd_value[`FPEC_IRQ_W-1:0] = next_st.irq_stat;
      end
      else if (AHB_I.haddr[7:0] == `FPEC_OFF_MASK)
      begin
         rd_value[`FPEC_IRQ_W-1:0] = next_st.irq_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLOCK_I)
   begin
      st <= next_st;
   end

   // outputs straight from the state register
   assign AHB_O = st.ahb;
   assign FLASH_REQ_O = st.req;
   assign LVD_EN_O = st.lvd_en;
   assign IRQ_O = st.irq;

endmodule : fpec_top

// ===== core/fpec_consts.svh
// Operation
// - start bit set only when armed and the unlock keys were just written
// - start bit launches the chosen operation; hardware clears it when finished
// - arm bit permits start writes and powers the low-supply detector
// - every reset clears the arm bit
// - failure flag set when a program or erase does not complete
// - failure and low-supply flags clear only on power-on or a started 0000
// - fault flag set on low supply while the detector is on
// - live flag follows an active low-supply event, hardware only
// - operation code writable only while disarmed
// - code 0101 erases the whole array unless any page is protected
// - code 0100 erases the addressed page unless it is protected
// - code 0011 programs the addressed row unless it is protected
// - code 0001 programs the addressed word unless it is protected
// - code 0000 clears the failure and fault flags, 0010 does nothing; 0110 to 1111 are reserved
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH

// register byte offsets
`define FPEC_OFF_CTRL 8'h00
`define FPEC_OFF_KEY 8'h04
`define FPEC_OFF_ADDR 8'h08
`define FPEC_OFF_STAT 8'h0C
`define FPEC_OFF_MASK 8'h10

// control register fields
`define FPEC_BIT_START 15
`define FPEC_BIT_ARM 14
`define FPEC_BIT_FAIL 13
`define FPEC_BIT_FAULT 12
`define FPEC_BIT_LIVE 11
`define FPEC_OP_HI 3
`define FPEC_OP_LO 0

// operation codes
`define FPEC_OP_CLEAR 4'h0
`define FPEC_OP_WORD 4'h1
`define FPEC_OP_NOP 4'h2
`define FPEC_OP_ROW 4'h3
`define FPEC_OP_PAGE 4'h4
`define FPEC_OP_CHIP 4'h5

// unlock keys, values arbitrary
`define FPEC_KEY_FIRST 32'hC0DE_0001
`define FPEC_KEY_SECOND 32'hC0DE_0002

// interrupt status bits
`define FPEC_IRQ_W 3
`define FPEC_IRQ_DONE 0
`define FPEC_IRQ_FAIL 1
`define FPEC_IRQ_FAULT 2

// reset values
`define FPEC_ZERO32 32'h0000_0000
`define FPEC_ZERO4 4'h0
`define FPEC_ZERO_IRQ 3'h0
`define FPEC_ZERO8 8'h00

`endif

// ===== core/fpec_pkg.sv
package fpec_pkg;

   // sequencer states
   typedef enum logic [1:0] {FPEC_IDLE, FPEC_CHECK, FPEC_BUSY, FPEC_FINISH} fpec_fsm_type;

   // ahb-lite slave inputs
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } fpec_ahb_in_type;

   // ahb-lite slave outputs
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } fpec_ahb_out_type;

   // request to the flash array
   typedef struct packed {
      logic valid;
      logic [3:0] op;
      logic [31:0] addr;
   } fpec_flash_req_type;

   // answer and protection from the flash array
   typedef struct packed {
      logic done;
      logic err;
      logic target_prot;
      logic any_prot;
   } fpec_flash_rsp_type;

   // low-supply qualifier state
   typedef struct packed {
      logic live;
      logic rise;
   } fpec_lvd_state_type;

   // main state
   typedef struct packed {
      fpec_fsm_type fsm;
      logic arm;
      logic start;
      logic fail;
      logic fault;
      logic [3:0] op;
      logic [31:0] addr;
      logic key_seen;
      logic unlocked;
      logic dp_write;
      logic [7:0] dp_addr;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic lvd_en;
      fpec_ahb_out_type ahb;
      fpec_flash_req_type req;
   } fpec_state_type;

endpackage : fpec_pkg

// ===== core/fpec_lvd.sv
`timescale 1ns/1ps

module fpec_lvd
(
   input wire logic clock_i, // system clock
   input wire logic rst_b_i, // synchronous reset, active low
   input wire logic enable_i, // detector powered
   input wire logic low_supply_i, // raw low-supply level
   output fpec_pkg::fpec_lvd_state_type lvd_o // live level and rise pulse
);
   import fpec_pkg::*;

   fpec_lvd_state_type st;
   fpec_lvd_state_type next_st;

   // live follows the detector only while it is powered
   always_comb
   begin
      next_st.live = enable_i & low_supply_i;
      next_st.rise = enable_i & low_supply_i & ~st.live;
      if (!rst_b_i)
      begin
         next_st.live = 1'b0;
         next_st.rise = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clock_i)
   begin
      st <= next_st;
   end

   assign lvd_o = st;

endmodule : fpec_lvd

// ===== verification/fpec_assertions.sv
`timescale 1ns/1ps

module fpec_assertions
(
   input wire logic CLOCK_I, // system clock
   input wire logic RST_B_I, // reset, active low
   input wire logic POWER_ON_I, // power-on qualifier
   input fpec_pkg::fpec_ahb_in_type AHB_I, // bus inputs
   input fpec_pkg::fpec_ahb_out_type AHB_O, // bus outputs
   input fpec_pkg::fpec_flash_req_type FLASH_REQ_O, // flash request
   input fpec_pkg::fpec_flash_rsp_type FLASH_RSP_I, // flash answer
   input wire logic LOW_SUPPLY_I, // raw low supply
   input wire logic LVD_EN_O, // detector power
   input wire logic IRQ_O // interrupt
);
   import fpec_pkg::*;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   ////////////////////////////////////////
   // bus answers at once and cleanly
   a_ready_okay: assert property (AHB_O.hreadyout && !AHB_O.hresp)
      else $error("bus slave stalled or erred");
   a_rdata_idle: assert property
      (!$past(AHB_I.hsel && AHB_I.htrans[1] && !AHB_I.hwrite) |-> AHB_O.hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");
   // request lifecycle
   a_req_armed: assert property ($rose(FLASH_REQ_O.valid) |-> $past(LVD_EN_O, 2))
      else $error("request launched while disarmed");
   a_req_hold: assert property (FLASH_REQ_O.valid && !FLASH_RSP_I.done
      && !$past(FLASH_RSP_I.done) |=> FLASH_REQ_O.valid) else $error("request dropped early");
   a_req_drop: assert property (FLASH_RSP_I.done |-> ##[1:2] !FLASH_REQ_O.valid)
      else $error("request held after done");
   a_req_stable: assert property (FLASH_REQ_O.valid && $past(FLASH_REQ_O.valid)
      |-> $stable(FLASH_REQ_O.op) && $stable(FLASH_REQ_O.addr)) else $error("request moved");
   a_op_legal: assert property (FLASH_REQ_O.valid
      |-> FLASH_REQ_O.op inside {4'h1, 4'h3, 4'h4, 4'h5}) else $error("idle code sent");
   a_reset_quiet: assert property ($rose(RST_B_I)
      |-> !LVD_EN_O && !IRQ_O && !FLASH_REQ_O.valid) else $error("outputs live after reset");
   // main scenarios
   cover property (FLASH_RSP_I.done && FLASH_RSP_I.err);
   cover property ($rose(IRQ_O));
   cover property (LVD_EN_O && LOW_SUPPLY_I);
endmodule : fpec_assertions

bind fpec_top fpec_assertions fpec_assertions_inst (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
   .POWER_ON_I(POWER_ON_I), .AHB_I(AHB_I), .AHB_O(AHB_O), .FLASH_REQ_O(FLASH_REQ_O),
   .FLASH_RSP_I(FLASH_RSP_I), .LOW_SUPPLY_I(LOW_SUPPLY_I), .LVD_EN_O(LVD_EN_O), .IRQ_O(IRQ_O));

// ===== verification/fpec_flash_model.sv
`timescale 1ns/1ps

module fpec_flash_model
(
   input wire logic clock_i, // system clock
   input wire logic rst_b_i, // reset, active low
   input fpec_pkg::fpec_flash_req_type req_i, // request from block
   input wire logic [3:0] delay_i, // answer delay, 0 to 7
   input wire logic err_i, // answer with error
   input wire logic prot_i, // target and array protected
   output fpec_pkg::fpec_flash_rsp_type rsp_o // answer to block
);
   import fpec_pkg::*;
   logic [3:0] count;
   logic done;
   logic err;
   ////////////////////////////////////////
   // one done pulse per request, error line junk otherwise
   always_ff @(posedge clock_i)
   begin
      done <= rst_b_i && req_i.valid && count == delay_i;
      err <= (count == delay_i) ? err_i : ~err_i;
      count <= (!rst_b_i || !req_i.valid) ? 4'h0 : (count == delay_i) ? 4'hF : count + 4'h1;
   end
   // protection levels feed page, row, word and array checks
   assign rsp_o = '{done: done, err: err, target_prot: prot_i, any_prot: prot_i};
endmodule : fpec_flash_model

// ===== verification/fpec_top_tb.sv
`timescale 1ns/1ps
`include "fpec_consts.svh"

module fpec_top_tb;
   import fpec_pkg::*;
   localparam logic [31:0] CT = 32'h0000_0000 | `FPEC_OFF_CTRL;
   localparam logic [31:0] KY = 32'h0000_0000 | `FPEC_OFF_KEY;
   localparam logic [31:0] AD = 32'h0000_0000 | `FPEC_OFF_ADDR;
   localparam logic [31:0] ST = 32'h0000_0000 | `FPEC_OFF_STAT;
   localparam logic [31:0] MK = 32'h0000_0000 | `FPEC_OFF_MASK;
   localparam logic [31:0] ARM = 32'h0000_4000;
   localparam logic [31:0] GO = 32'h0000_8000;
   logic CLOCK_I = 0, RST_B_I = 0, POWER_ON_I = 1, LOW_SUPPLY_I = 0, LVD_EN_O, IRQ_O;
   logic ferr = 0, prot = 0, vd = 0, rdp = 0, fail_e = 0, fault_e = 0;
   logic [3:0] dly = 4'h0;
   logic [3:0] xop = 4'h0;
   logic [31:0] xad = 32'h0000_0000;
   logic [31:0] q[$];
   int mismatches = 0, n_compared = 0, seed = 38, nreq = 0, n0 = 0;
   fpec_ahb_in_type ahb = '0;
   fpec_ahb_in_type ahb_in;
   fpec_ahb_out_type AHB_O;
   fpec_flash_req_type req;
   fpec_flash_rsp_type rsp;
   fpec_top fpec_top_inst (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .POWER_ON_I(POWER_ON_I),
      .AHB_I(ahb_in), .AHB_O(AHB_O), .FLASH_REQ_O(req), .FLASH_RSP_I(rsp),
      .LOW_SUPPLY_I(LOW_SUPPLY_I), .LVD_EN_O(LVD_EN_O), .IRQ_O(IRQ_O));
   fpec_flash_model fpec_flash_model_inst (.clock_i(CLOCK_I), .rst_b_i(RST_B_I), .req_i(req),
      .delay_i(dly), .err_i(ferr), .prot_i(prot), .rsp_o(rsp));
   ////////////////////////////////////////
   // clock and the bus ready loop
   always #50 CLOCK_I = ~CLOCK_I;
   always_comb
   begin
      ahb_in = ahb;
      ahb_in.hready = AHB_O.hreadyout;
   end
   // read results against the oldest note
   always @(posedge CLOCK_I)
   begin
      if (rdp) check(AHB_O.hrdata, q.pop_front());
      rdp <= ahb.hsel && ahb.htrans[1] && !ahb.hwrite;
      if (req.valid) nreq <= nreq + 1;
      vd <= req.valid;
      if (req.valid && !vd) check({28'h0, req.op}, {28'h0, xop});
      if (req.valid && !vd) check(req.addr, xad);
   end
   // watchdog
   initial
   begin
      repeat (20000) @(posedge CLOCK_I);
      mismatches++;
      results();
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, got, exp);
      end
   endtask : check
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      ahb.hsel <= 1'b1;
      ahb.haddr <= a;
      ahb.htrans <= 2'b10;
      ahb.hwrite <= w;
      ahb.hsize <= 3'b010;
      do @(posedge CLOCK_I); while (ahb_in.hready !== 1'b1);
      ahb.hsel <= 1'b0;
      ahb.htrans <= 2'b00;
      ahb.hwdata <= w ? d : $random(seed);
      do @(posedge CLOCK_I); while (ahb_in.hready !== 1'b1);
   endtask : xfer
   task rd(input logic [31:0] a, input logic [31:0] e);
      q.push_back(e);
      xfer(1'b0, a, 32'h0000_0000);
   endtask : rd
   task rst(input logic po);
      RST_B_I <= 1'b0;
      POWER_ON_I <= po;
      repeat (4) @(posedge CLOCK_I);
      RST_B_I <= 1'b1;
      @(posedge CLOCK_I);
   endtask : rst
   function logic [31:0] ctl(input logic [31:0] x);
      return x | {18'h0, fail_e, fault_e, 12'h0};
   endfunction : ctl
   // one armed, unlocked operation with random delay
   task go(input logic [3:0] op, input logic e, input logic p);
      logic hit;
      hit = op inside {4'h1, 4'h3, 4'h4, 4'h5};
      xop = op;
      xfer(1'b1, CT, 32'h0000_0000);
      xfer(1'b1, CT, {28'h0, op});
      xfer(1'b1, CT, ARM | op);
      xfer(1'b1, CT, ARM | {28'h0, ~op});
      rd(CT, ctl(ARM | op));
      xad = $random(seed);
      xfer(1'b1, AD, xad);
      ferr <= e;
      prot <= p;
      dly <= 4'($random(seed)) & 4'h7;
      xfer(1'b1, KY, `FPEC_KEY_FIRST);
      xfer(1'b1, KY, `FPEC_KEY_SECOND);
      n0 = nreq;
      xfer(1'b1, CT, GO | ARM | op);
      for (int i = 0; i < 40 && IRQ_O !== 1'b1; i++) @(posedge CLOCK_I);
      check({31'h0, IRQ_O}, 32'h0000_0001);
      check({31'h0, nreq != n0}, {31'h0, hit && !p});
      if (op == 4'h0) {fail_e, fault_e} = 2'b00;
      fail_e |= hit && (e || p);
      rd(CT, ctl(ARM | op));
      rd(ST, {30'h0, hit && (e || p), 1'b1});
      xfer(1'b1, ST, 32'h0000_0007);
      @(posedge CLOCK_I);
      check({31'h0, IRQ_O}, 32'h0000_0000);
   endtask : go
   task results;
      @(posedge CLOCK_I);
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   ////////////////////////////////////////
   // main sequence
   initial
   begin
      rst(1'b1);
      rd(CT, 32'h0000_0000);
      rd(MK, 32'h0000_0000);
      xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
      rd(32'h0000_0040, 32'h0000_0000);
      xfer(1'b1, MK, 32'h0000_0001);
      for (int i = 0; i < 32; i++) go(4'(i), 1'($random(seed)), ($random(seed) & 3) == 0);
      n0 = nreq;
      xfer(1'b1, CT, GO | ARM | 32'h0000_0001);
      xfer(1'b1, KY, `FPEC_KEY_FIRST);
      xfer(1'b1, AD, 32'h0000_0000);
      xfer(1'b1, KY, `FPEC_KEY_SECOND);
      xfer(1'b1, CT, GO | ARM | 32'h0000_0001);
      xfer(1'b1, CT, 32'h0000_0001);
      xfer(1'b1, KY, `FPEC_KEY_FIRST);
      xfer(1'b1, KY, `FPEC_KEY_SECOND);
      xfer(1'b1, CT, GO | 32'h0000_0001);
      rd(CT, ctl(32'h0000_0001));
      check({31'h0, nreq != n0}, 32'h0000_0000);
      go(4'h1, 1'b1, 1'b0);
      rst(1'b0);
      rd(CT, ctl(32'h0000_0001));
      xfer(1'b1, CT, ARM | 32'h0000_0001);
      LOW_SUPPLY_I <= 1'b1;
      repeat (3) @(posedge CLOCK_I);
      check({31'h0, LVD_EN_O}, 32'h0000_0001);
      fault_e = 1'b1;
      rd(CT, ctl(ARM | 32'h0000_0801));
      LOW_SUPPLY_I <= 1'b0;
      repeat (2) @(posedge CLOCK_I);
      rd(CT, ctl(ARM | 32'h0000_0001));
      rd(ST, 32'h0000_0004);
      xfer(1'b1, CT, 32'h0000_0000);
      LOW_SUPPLY_I <= 1'b1;
      repeat (3) @(posedge CLOCK_I);
      check({31'h0, LVD_EN_O}, 32'h0000_0000);
      rd(CT, ctl(32'h0000_0001));
      LOW_SUPPLY_I <= 1'b0;
      xfer(1'b1, ST, 32'h0000_0007);
      xfer(1'b1, MK, 32'h0000_0001);
      go(4'h0, 1'b0, 1'b0);
      rst(1'b1);
      rd(CT, 32'h0000_0000);
      results();
   end
endmodule : fpec_top_tb
